// ---- logic/dcsp_serial_port.sv ----
`timescale 1ns/10ps
// What this block does
// - Two independent channels A and B, each with its own transmit and receive lines.
// - Bit rate per channel chosen from 110 to 9600 bps; both ends match.
// - Seven or eight data bits per character, chosen by configuration.
// - Parity even, odd or none; generated on transmit, checked on receive.
// - Half duplex: a channel never transmits and receives at once.
// - Send request is on while transmitting, off once transmission completes.
// - Transmit only with transmit enable on; at most two bytes after it drops.
// - Receive enable output is on when input is accepted, off when disabled.
// - Characters arriving while input is disabled or an error is pending are discarded.
// - A receive error turns receive enable off until the error is cleared.
// - Data set ready dropping during transfer flags an error.
// - Data set ready and transmit enable monitoring can each be masked.
// - Terminal ready output stays on whenever the device is powered.
// - Channel A alone takes carrier present and call indicator inputs.
// - Channel A takes element timing inputs for synchronous character mode.
module dcsp_serial_port #(
    parameter int NCH   = dcsp_pkg::NUM_CHAN,
    parameter int DEPTH = dcsp_pkg::FIFO_DEPTH
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    // Per-channel configuration
    input  wire logic [NCH-1:0][3:0]        rateSel,
    input  wire logic [NCH-1:0]             eightBits,
    input  wire logic [NCH-1:0][1:0]        parityMode,
    input  wire logic [NCH-1:0]             twoStops,
    input  wire logic [NCH-1:0]             dsrMonitor,
    input  wire logic [NCH-1:0]             ctsMonitor,
    input  wire logic [NCH-1:0]             rxEnable,
    input  wire logic [NCH-1:0]             errClear,
    // Transmit data stream
    input  wire logic [NCH-1:0][7:0]        txData,
    input  wire logic [NCH-1:0]             txValid,
    output logic      [NCH-1:0]             txReady,
    // Receive data stream
    output logic      [NCH-1:0][7:0]        rxData,
    output logic      [NCH-1:0]             rxValid,
    input  wire logic [NCH-1:0]             rxReady,
    // Sticky error flags
    output logic      [NCH-1:0]             parityErr,
    output logic      [NCH-1:0]             framingErr,
    output logic      [NCH-1:0]             overrunErr,
    output logic      [NCH-1:0]             dsrErr,
    // Serial line pins
    output logic      [NCH-1:0]             serial_out_line,
    input  wire logic [NCH-1:0]             serialIn,
    output logic      [NCH-1:0]             send_request_out,
    input  wire logic [NCH-1:0]             transmitEnableIn,
    output logic      [NCH-1:0]             receiveEnableOut,
    input  wire logic [NCH-1:0]             data_set_ready_in,
    output logic      [NCH-1:0]             terminal_ready_out,
    // Channel A extras
    input  wire logic                       carrier_present_in,
    input  wire logic                       call_indicator_in,
    input  wire logic                       receive_element_timing,
    input  wire logic                       transmit_element_timing,
    input  wire logic                       syncModeA,
    output logic                            carrierPresent,
    output logic                            callIndicated
);
    typedef enum logic [2:0] {
        SP_IDLE  = 3'h0,
        SP_START = 3'h1,
        SP_DATA  = 3'h3,
        SP_PAR   = 3'h2,
        SP_STOP  = 3'h6
    } dcsp_state_t;

    // Channel A status lines are registered to keep data outputs from flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            carrierPresent <= 1'b0;
            callIndicated  <= 1'b0;
        end else begin
            carrierPresent <= carrier_present_in;
            callIndicated  <= call_indicator_in;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            dcsp_fifo_if #(.WIDTH(8)) txq ();
            dcsp_fifo_if #(.WIDTH(8)) rxq ();
            dcsp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (.sys_clk(sys_clk), .srst(srst), .port(txq.fifo));
            dcsp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxq (.sys_clk(sys_clk), .srst(srst), .port(rxq.fifo));

            // Synchronous mode: element timing edges replace the baud divider (channel A)
            logic useSync;
            logic txTimPrev, rxTimPrev;
            assign useSync = (ch == 0) && syncModeA;

            dcsp_state_t      txSt, next_txSt, rxSt, next_rxSt;
            logic [16:0]      txCnt, next_txCnt, rxCnt, next_rxCnt;
            logic [2:0]       txBit, next_txBit, rxBit, next_rxBit;
            logic [7:0]       txSh, next_txSh, rxSh, next_rxSh;
            logic             txPar, next_txPar, rxPar, next_rxPar;
            logic             stop2, next_stop2;
            logic [1:0]       afterDrop, next_afterDrop;
            logic             rxDiscard, next_rxDiscard;
            logic             lineOut, next_lineOut;
            logic             pErr, next_pErr, fErr, next_fErr, oErr, next_oErr, dErr, next_dErr;
            logic [7:0]       rxWord, next_rxWord;
            logic             rxPush, next_rxPush;
            logic [16:0]      bitLen;
            logic             txTick, rxTick, rxHalf, ctsOk, anyErr, rxOpen;

            assign bitLen  = dcsp_pkg::bit_cycles(rateSel[ch]);
            assign txTick  = useSync ? (transmit_element_timing && !txTimPrev)
                                     : (txCnt == bitLen - 17'h1);
            assign rxTick  = useSync ? (receive_element_timing && !rxTimPrev)
                                     : (rxCnt == bitLen - 17'h1);
            assign rxHalf  = useSync ? (receive_element_timing && !rxTimPrev) : (rxCnt == (bitLen >> 1));
            assign ctsOk   = !ctsMonitor[ch] || transmitEnableIn[ch];
            assign anyErr  = pErr || fErr || oErr || dErr;
            assign rxOpen  = rxEnable[ch] && !anyErr;

            // Transmit: one character in flight; pause bytes count beyond a dropped enable
            always_comb begin
                next_txSt      = txSt;
                next_txCnt     = (txTick || txSt == SP_IDLE) ? 17'h0 : txCnt + 17'h1;
                next_txBit     = txBit;
                next_txSh      = txSh;
                next_txPar     = txPar;
                next_stop2     = stop2;
                next_lineOut   = lineOut;
                next_afterDrop = ctsOk ? 2'h0 : afterDrop;
                txq.outReady   = 1'b0;
                case (txSt)
                    SP_IDLE: begin
                        next_lineOut = 1'b1;
                        // Start only if line is quiet inbound and enable allows
                        if (txq.outValid && rxSt == SP_IDLE && serialIn[ch] &&
                            (ctsOk || afterDrop < 2'(dcsp_pkg::PAUSE_BYTES)) && !dErr) begin
                            txq.outReady = 1'b1;
                            next_txSh    = txq.outData;
                            next_txPar   = (parityMode[ch] == dcsp_pkg::PAR_ODD);
                            next_txBit   = 3'h0;
                            next_stop2   = 1'b0;
                            next_lineOut = 1'b0;
                            next_txSt    = SP_START;
                            if (!ctsOk) begin
                                next_afterDrop = afterDrop + 2'h1;
                            end
                        end
                    end
                    SP_START: if (txTick) begin
                        next_lineOut = txSh[0];
                        next_txSt    = SP_DATA;
                    end
                    SP_DATA: if (txTick) begin
                        next_txPar = txPar ^ txSh[0];
                        next_txSh  = {1'b0, txSh[7:1]};
                        next_txBit = txBit + 3'h1;
                        if (txBit == (eightBits[ch] ? 3'h7 : 3'h6)) begin
                            if (parityMode[ch] != dcsp_pkg::PAR_NONE) begin
                                next_lineOut = txPar ^ txSh[0];
                                next_txSt    = SP_PAR;
                            end else begin
                                next_lineOut = 1'b1;
                                next_txSt    = SP_STOP;
                            end
                        end else begin
                            next_lineOut = txSh[1];
                        end
                    end
                    SP_PAR: if (txTick) begin
                        next_lineOut = 1'b1;
                        next_txSt    = SP_STOP;
                    end
                    SP_STOP: if (txTick) begin
                        if (twoStops[ch] && !stop2) begin
                            next_stop2 = 1'b1;
                        end else begin
                            next_txSt = SP_IDLE;
                        end
                    end
                    default: next_txSt = SP_IDLE;
                endcase
            end

            // Receive: sample mid-bit; flags are sticky and set wins over clear
            always_comb begin
                next_rxSt      = rxSt;
                next_rxCnt     = (rxTick || rxSt == SP_IDLE) ? 17'h0 : rxCnt + 17'h1;
                next_rxBit     = rxBit;
                next_rxSh      = rxSh;
                next_rxPar     = rxPar;
                next_rxDiscard = rxDiscard;
                next_rxWord    = rxWord;
                next_rxPush    = 1'b0;
                next_pErr      = errClear[ch] ? 1'b0 : pErr;
                next_fErr      = errClear[ch] ? 1'b0 : fErr;
                next_oErr      = errClear[ch] ? 1'b0 : oErr;
                next_dErr      = errClear[ch] ? 1'b0 : dErr;
                if (dsrMonitor[ch] && !data_set_ready_in[ch] && (txSt != SP_IDLE || rxSt != SP_IDLE)) begin
                    next_dErr = 1'b1;
                end
                case (rxSt)
                    SP_IDLE: if (!serialIn[ch] && txSt == SP_IDLE) begin
                        next_rxSt      = SP_START;
                        next_rxDiscard = !rxOpen;
                        next_rxBit     = 3'h0;
                        next_rxPar     = (parityMode[ch] == dcsp_pkg::PAR_ODD);
                    end
                    SP_START: if (rxHalf) begin
                        // Restart the count at mid start so data is sampled mid-bit
                        next_rxCnt = 17'h0;
                        next_rxSt  = serialIn[ch] ? SP_IDLE : SP_DATA;
                    end
                    SP_DATA: if (rxTick) begin
                        next_rxSh  = {serialIn[ch], rxSh[7:1]};
                        next_rxPar = rxPar ^ serialIn[ch];
                        next_rxBit = rxBit + 3'h1;
                        if (rxBit == (eightBits[ch] ? 3'h7 : 3'h6)) begin
                            next_rxSt = (parityMode[ch] != dcsp_pkg::PAR_NONE) ? SP_PAR : SP_STOP;
                        end
                    end
                    SP_PAR: if (rxTick) begin
                        next_rxSt = SP_STOP;
                        if ((rxPar ^ serialIn[ch]) && !rxDiscard) begin
                            next_pErr = 1'b1;
                        end
                    end
                    SP_STOP: if (rxTick) begin
                        next_rxSt = SP_IDLE;
                        if (!rxDiscard) begin
                            if (!serialIn[ch]) begin
                                next_fErr = 1'b1;
                            end else if (!rxq.inReady) begin
                                next_oErr = 1'b1;
                            end else begin
                                next_rxWord = eightBits[ch] ? rxSh : {1'b0, rxSh[7:1]};
                                next_rxPush = 1'b1;
                            end
                        end
                    end
                    default: next_rxSt = SP_IDLE;
                endcase
            end

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    txSt <= SP_IDLE; rxSt <= SP_IDLE;
                    txCnt <= '0; rxCnt <= '0; txBit <= '0; rxBit <= '0;
                    txSh <= '0; rxSh <= '0; txPar <= 1'b0; rxPar <= 1'b0;
                    stop2 <= 1'b0; afterDrop <= '0; rxDiscard <= 1'b0; lineOut <= 1'b1;
                    pErr <= 1'b0; fErr <= 1'b0; oErr <= 1'b0; dErr <= 1'b0;
                    rxWord <= '0; rxPush <= 1'b0; txTimPrev <= 1'b0; rxTimPrev <= 1'b0;
                end else begin
                    txSt <= next_txSt; rxSt <= next_rxSt;
                    txCnt <= next_txCnt; rxCnt <= next_rxCnt; txBit <= next_txBit; rxBit <= next_rxBit;
                    txSh <= next_txSh; rxSh <= next_rxSh; txPar <= next_txPar; rxPar <= next_rxPar;
                    stop2 <= next_stop2; afterDrop <= next_afterDrop; rxDiscard <= next_rxDiscard;
                    lineOut <= next_lineOut;
                    pErr <= next_pErr; fErr <= next_fErr; oErr <= next_oErr; dErr <= next_dErr;
                    rxWord <= next_rxWord; rxPush <= next_rxPush;
                    txTimPrev <= transmit_element_timing; rxTimPrev <= receive_element_timing;
                end
            end

            // Push happens one cycle after the stop check; the stop check saw inReady
            assign rxq.inData   = rxWord;
            assign rxq.inValid  = rxPush;
            assign rxq.outReady = rxReady[ch];
            assign txq.inData   = txData[ch];
            assign txq.inValid  = txValid[ch];

            assign txReady[ch]            = txq.inReady;
            assign rxData[ch]             = rxq.outData;
            assign rxValid[ch]            = rxq.outValid;
            assign parityErr[ch]          = pErr;
            assign framingErr[ch]         = fErr;
            assign overrunErr[ch]         = oErr;
            assign dsrErr[ch]             = dErr;
            assign serial_out_line[ch]    = lineOut;
            assign send_request_out[ch]   = (txSt != SP_IDLE);
            assign receiveEnableOut[ch]   = rxOpen && rxq.inReady;
            assign terminal_ready_out[ch] = 1'b1;
        end
    endgenerate
endmodule

// ---- logic/dcsp_pkg.sv ----
package dcsp_pkg;
    localparam int          NUM_CHAN       = 2;
    localparam int          SYS_CLK_HZ     = 10_000_000;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          CHAR_W         = 8;
    localparam int          PAUSE_BYTES    = 2;
    localparam int          NUM_RATES      = 9;
    localparam logic [3:0]  RATE_RESET     = 4'h5;
    // Bit rates in bits per second, index = rate select
    localparam int          RATE_BPS [0:8] = '{110, 150, 200, 300, 600, 1200, 2400, 4800, 9600};
    localparam int          DIV_W          = 17;
    // Parity modes
    localparam logic [1:0]  PAR_NONE       = 2'h0;
    localparam logic [1:0]  PAR_EVEN       = 2'h1;
    localparam logic [1:0]  PAR_ODD        = 2'h2;
    function automatic logic [DIV_W-1:0] bit_cycles(input logic [3:0] sel);
        int idx;
        idx = (sel < 4'(NUM_RATES)) ? int'(sel) : int'(RATE_RESET);
        return DIV_W'(SYS_CLK_HZ / RATE_BPS[idx]);
    endfunction
endpackage

// ---- logic/dcsp_fifo_if.sv ----
`timescale 1ns/10ps
interface dcsp_fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] inData;
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] outData;
    logic             outValid;
    logic             outReady;
    modport fifo (input inData, input inValid, output inReady, output outData, output outValid, input outReady);
    modport user (output inData, output inValid, input inReady, input outData, input outValid, output outReady);
endinterface

// ---- logic/dcsp_fifo.sv ----
`timescale 1ns/10ps
module dcsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    dcsp_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wrPtr;
    logic [AW-1:0]    next_rdPtr;
    logic [AW:0]      next_count;
    logic             doWr;
    logic             doRd;

    assign port.inReady  = (count != (AW+1)'(DEPTH));
    assign port.outValid = (count != '0);
    assign port.outData  = mem[rdPtr];
    assign doWr = port.inValid && port.inReady;
    assign doRd = port.outValid && port.outReady;

    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (doWr) begin
            next_wrPtr = (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
        end
        if (doRd) begin
            next_rdPtr = (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
        end
        if (doWr && !doRd) begin
            next_count = count + 1'b1;
        end else if (doRd && !doWr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
        if (doWr) begin
            mem[wrPtr] <= port.inData;
        end
    end
endmodule

// ---- test/dcsp_serial_port_properties.sv ----
`timescale 1ns/10ps
module dcsp_serial_port_properties #(
    parameter int NCH = 2
) (
    input wire logic           sys_clk,
    input wire logic           srst,
    input wire logic [NCH-1:0] rxEnable,
    input wire logic [NCH-1:0] errClear,
    input wire logic [NCH-1:0] dsrMonitor,
    input wire logic [NCH-1:0] ctsMonitor,
    input wire logic [NCH-1:0] parityErr,
    input wire logic [NCH-1:0] framingErr,
    input wire logic [NCH-1:0] overrunErr,
    input wire logic [NCH-1:0] dsrErr,
    input wire logic [NCH-1:0] serial_out_line,
    input wire logic [NCH-1:0] send_request_out,
    input wire logic [NCH-1:0] transmitEnableIn,
    input wire logic [NCH-1:0] receiveEnableOut,
    input wire logic [NCH-1:0] data_set_ready_in,
    input wire logic [NCH-1:0] terminal_ready_out,
    input wire logic           carrier_present_in,
    input wire logic           call_indicator_in,
    input wire logic           carrierPresent,
    input wire logic           callIndicated
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [2:0] txStarts;
    logic       reqSeen;
    // Starts counted only after the drop; a frame already running is not one of them
    always_ff @(posedge sys_clk) begin
        reqSeen <= send_request_out[0];
        if (srst || !ctsMonitor[0] || transmitEnableIn[0]) begin
            txStarts <= 3'h0;
        end else if (send_request_out[0] && !reqSeen && txStarts != 3'h7) begin
            txStarts <= txStarts + 3'h1;
        end
    end
    AST_TERM_READY: assert property (terminal_ready_out == '1)
        else $error("terminal ready dropped");
    AST_RX_EN_SW: assert property ((receiveEnableOut & ~rxEnable) == '0)
        else $error("receive enable on while input disabled");
    AST_ERR_BLOCKS: assert property ((receiveEnableOut & (parityErr | framingErr | overrunErr | dsrErr)) == '0)
        else $error("receive enable on with an error pending");
    AST_FLAG_STICKY: assert property (!$past(srst) |->
        (($past(parityErr | framingErr | overrunErr | dsrErr) & ~(parityErr | framingErr | overrunErr | dsrErr)
        & ~$past(errClear)) == '0)) else $error("error flag cleared without clear request");
    AST_IDLE_LINE: assert property ((~send_request_out & ~serial_out_line) == '0)
        else $error("line low while no send request");
    AST_START_BIT: assert property ($rose(send_request_out[0]) |-> !serial_out_line[0] [*8])
        else $error("start bit missing or short");
    AST_DSR_FLAG: assert property (dsrMonitor[1] && !data_set_ready_in[1] && send_request_out[1]
        |-> ##[1:2] dsrErr[1]) else $error("data set ready loss not flagged");
    AST_EXTRAS: assert property (!$past(srst) |-> carrierPresent == $past(carrier_present_in)
        && callIndicated == $past(call_indicator_in)) else $error("channel A extras not mirrored");
    AST_CTS_LIMIT: assert property (txStarts <= 3'h2)
        else $error("too many characters after transmit enable dropped");
    cover property ($rose(send_request_out[0]));
    cover property ($rose(parityErr[0]));
    cover property ($rose(dsrErr[1]));
endmodule

bind dcsp_serial_port dcsp_serial_port_properties #(.NCH(NCH)) u_dcsp_serial_port_properties (
    .sys_clk(sys_clk), .srst(srst), .rxEnable(rxEnable), .errClear(errClear), .dsrMonitor(dsrMonitor),
    .ctsMonitor(ctsMonitor), .parityErr(parityErr), .framingErr(framingErr), .overrunErr(overrunErr),
    .dsrErr(dsrErr), .serial_out_line(serial_out_line), .send_request_out(send_request_out),
    .transmitEnableIn(transmitEnableIn), .receiveEnableOut(receiveEnableOut),
    .data_set_ready_in(data_set_ready_in), .terminal_ready_out(terminal_ready_out),
    .carrier_present_in(carrier_present_in), .call_indicator_in(call_indicator_in),
    .carrierPresent(carrierPresent), .callIndicated(callIndicated));

// ---- test/dcsp_serial_partner.sv ----
`timescale 1ns/10ps
module dcsp_serial_partner #(
    parameter int BIT_LEN = 1041
) (
    input  wire logic sys_clk,
    output logic      lineOut,
    input  wire logic lineIn
);
    logic [11:0] rxBits = '1;
    int          rxLen = 10;
    initial lineOut = 1'b1;
    // Same bit length both ways, frame built by the caller, line back to mark after it
    task automatic sendChar(input logic [11:0] frame, input int len);
        for (int i = 0; i < len; i++) begin
            lineOut = frame[i];
            repeat (BIT_LEN) @(posedge sys_clk);
            #1;
        end
        lineOut = 1'b1;
    endtask
    always begin
        @(negedge lineIn);
        repeat (BIT_LEN / 2) @(posedge sys_clk);
        for (int i = 0; i < rxLen; i++) begin
            rxBits[i] = lineIn;
            repeat (BIT_LEN) @(posedge sys_clk);
        end
    end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    localparam int   BIT_LEN = dcsp_pkg::SYS_CLK_HZ / 9600;
    logic            sys_clk = 1'b0;
    logic            srst = 1'b1;
    logic [1:0][3:0] rateSel = {4'h8, 4'h8};
    logic [1:0][1:0] parityMode = {dcsp_pkg::PAR_NONE, dcsp_pkg::PAR_EVEN};
    logic [1:0][7:0] txData = '0;
    logic [1:0][7:0] rxData;
    logic [1:0]      eightBits = 2'h3, twoStops = 2'h0, dsrMonitor = 2'h2, ctsMonitor = 2'h0;
    logic [1:0]      rxEnable = 2'h3, errClear = 2'h0, txValid = 2'h0, rxReady = 2'h0, txReady, rxValid;
    logic [1:0]      parityErr, framingErr, overrunErr, dsrErr, serial_out_line, serialIn, send_request_out;
    logic [1:0]      transmitEnableIn = 2'h3, receiveEnableOut, data_set_ready_in = 2'h3, terminal_ready_out;
    logic            carrier_present_in = 1'b0, call_indicator_in = 1'b0, carrierPresent, callIndicated;
    logic            lineA;
    logic            lineB = 1'b1;
    int              errors = 0, cmp_count = 0;
    assign serialIn = {lineB, lineA};
    always #50 sys_clk = ~sys_clk;
    dcsp_serial_port u_dcsp_serial_port (.sys_clk(sys_clk), .srst(srst), .rateSel(rateSel),
        .eightBits(eightBits), .parityMode(parityMode), .twoStops(twoStops), .dsrMonitor(dsrMonitor),
        .ctsMonitor(ctsMonitor), .rxEnable(rxEnable), .errClear(errClear), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .parityErr(parityErr),
        .framingErr(framingErr), .overrunErr(overrunErr), .dsrErr(dsrErr), .serial_out_line(serial_out_line),
        .serialIn(serialIn), .send_request_out(send_request_out), .transmitEnableIn(transmitEnableIn),
        .receiveEnableOut(receiveEnableOut), .data_set_ready_in(data_set_ready_in),
        .terminal_ready_out(terminal_ready_out), .carrier_present_in(carrier_present_in),
        .call_indicator_in(call_indicator_in), .receive_element_timing(1'b0), .transmit_element_timing(1'b0),
        .syncModeA(1'b0), .carrierPresent(carrierPresent), .callIndicated(callIndicated));
    dcsp_serial_partner #(.BIT_LEN(BIT_LEN)) u_dcsp_serial_partner (.sys_clk(sys_clk), .lineOut(lineA),
        .lineIn(serial_out_line[0]));
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A wait that runs out is a mismatch and ends the run
    task automatic waitBit(ref logic [1:0] sig, input int ch, input logic lvl);
        int n;
        n = 0;
        while (sig[ch] !== lvl && n < 40000) begin
            tick();
            n++;
        end
        `CHK("wait", lvl, sig[ch])
        if (sig[ch] !== lvl) begin
            results();
        end
    endtask
    task automatic sendByte(input int ch, input logic [7:0] d);
        `CHK("tx ready", 1'b1, txReady[ch])
        txData[ch] = d;
        txValid[ch] = 1'b1;
        tick();
        txValid[ch] = 1'b0;
    endtask
    task automatic readByte(input int ch, input logic [7:0] exp);
        waitBit(rxValid, ch, 1'b1);
        `CHK("rx data", exp, rxData[ch])
        rxReady[ch] = 1'b1;
        tick();
        rxReady[ch] = 1'b0;
    endtask
    // Start low, data LSB first, optional parity (flip spoils it), stop bits high
    function automatic logic [11:0] mkFrame(input logic [7:0] d, input int nb, input logic [1:0] pm, input logic flip);
        logic [11:0] f;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < nb; i++) f[i+1] = d[i];
        if (pm != dcsp_pkg::PAR_NONE) f[nb+1] = ^(d & 8'((1 << nb) - 1)) ^ (pm == dcsp_pkg::PAR_ODD) ^ flip;
        return f;
    endfunction
    initial begin
        repeat (5) tick();
        srst = 1'b0;
        tick();
        `CHK("line idle", 2'h3, serial_out_line)
        `CHK("req idle", 2'h0, send_request_out)
        `CHK("term ready", 2'h3, terminal_ready_out)
        `CHK("flags", 2'h0, parityErr | framingErr | overrunErr | dsrErr)
        u_dcsp_serial_partner.rxLen = 11;
        sendByte(0, 8'ha5);
        waitBit(send_request_out, 0, 1'b1);
        data_set_ready_in[0] = 1'b0;
        waitBit(send_request_out, 0, 1'b0);
        repeat (BIT_LEN) tick();
        `CHK("tx frame", mkFrame(8'ha5, 8, dcsp_pkg::PAR_EVEN, 1'b0), u_dcsp_serial_partner.rxBits)
        `CHK("dsr masked", 1'b0, dsrErr[0])
        data_set_ready_in[0] = 1'b1;
        eightBits[0] = 1'b0;
        parityMode[0] = dcsp_pkg::PAR_ODD;
        tick();
        u_dcsp_serial_partner.sendChar(mkFrame(8'h35, 7, dcsp_pkg::PAR_ODD, 1'b0), 10);
        readByte(0, 8'h35);
        u_dcsp_serial_partner.sendChar(mkFrame(8'h5a, 7, dcsp_pkg::PAR_ODD, 1'b1), 10);
        repeat (4) tick();
        `CHK("parity flag", 1'b1, parityErr[0])
        `CHK("rx en on error", 1'b0, receiveEnableOut[0])
        rxReady[0] = 1'b1;
        errClear[0] = 1'b1;
        tick();
        rxReady[0] = 1'b0;
        errClear[0] = 1'b0;
        tick();
        `CHK("flag cleared", 2'h1, {parityErr[0], receiveEnableOut[0]})
        rxEnable[0] = 1'b0;
        tick();
        `CHK("rx en off", 1'b0, receiveEnableOut[0])
        u_dcsp_serial_partner.sendChar(mkFrame(8'h11, 7, dcsp_pkg::PAR_ODD, 1'b0), 10);
        rxEnable[0] = 1'b1;
        repeat (4) tick();
        `CHK("discarded", 1'b0, rxValid[0])
        sendByte(1, 8'h0f);
        waitBit(send_request_out, 1, 1'b1);
        repeat (100) tick();
        data_set_ready_in[1] = 1'b0;
        repeat (3) tick();
        `CHK("dsr flag", 2'h2, {dsrErr[1], receiveEnableOut[1]})
        data_set_ready_in[1] = 1'b1;
        waitBit(send_request_out, 1, 1'b0);
        errClear[1] = 1'b1;
        carrier_present_in = 1'b1;
        tick();
        errClear[1] = 1'b0;
        tick();
        `CHK("dsr cleared", 1'b0, dsrErr[1])
        `CHK("carrier", 2'h2, {carrierPresent, callIndicated})
        carrier_present_in = 1'b0;
        call_indicator_in = 1'b1;
        repeat (2) tick();
        `CHK("call", 2'h1, {carrierPresent, callIndicated})
        results();
    end
endmodule
